// >>> hdl/mhrm_pkg.sv
// ************************************************************
// Host register map constants
// ************************************************************
package mhrm_pkg;

  // Bus geometry and axis count.
  localparam int DATA_W   = 16;
  localparam int ADDR_W   = 3;
  localparam int N_AXES   = 4;
  localparam int PARAM_W  = 32;

  // Word addresses, shared by the read and the write decode.
  localparam logic [2:0] ADDR_COMMAND   = 3'h0;
  localparam logic [2:0] ADDR_MODE_ONE  = 3'h1;
  localparam logic [2:0] ADDR_MODE_TWO  = 3'h2;
  localparam logic [2:0] ADDR_MODE_THREE = 3'h3;
  localparam logic [2:0] ADDR_OUTPUT    = 3'h4;
  localparam logic [2:0] ADDR_INTERP    = 3'h5;
  localparam logic [2:0] ADDR_DATA_LOW  = 3'h6;
  localparam logic [2:0] ADDR_DATA_HIGH = 3'h7;

  // Fields of the command word and of the output word.
  localparam int CMD_CODE_LSB  = 0;
  localparam int CMD_CODE_MSB  = 6;
  localparam int CMD_AXIS_LSB  = 8;
  localparam int CMD_AXIS_MSB  = 11;
  localparam int OUT_LOW_MSB   = 3;

  // Command codes that this block itself reacts to.
  localparam logic [6:0] CMD_PATTERN_ENABLE  = 7'h36;
  localparam logic [6:0] CMD_PATTERN_DISABLE = 7'h37;

  // Values after reset.
  localparam logic [15:0] RESET_WORD     = 16'h0000;
  localparam logic [31:0] RESET_PARAM    = 32'h0000_0000;
  localparam logic [3:0]  RESET_AXIS_SEL = 4'h1;
  localparam logic [2:0]  STROBE_IDLE    = 3'h7;

  // Command acceptance time, a longest time, so it rounds down.
  localparam int CLK_PERIOD_NS = 40;
  localparam int CMD_ACCEPT_NS = 250;
  localparam int BUSY_W        = 4;
  localparam logic [BUSY_W-1:0] CMD_ACCEPT_CYCLES =
    BUSY_W'(CMD_ACCEPT_NS / CLK_PERIOD_NS);
  localparam logic [BUSY_W-1:0] BUSY_IDLE = 4'h0;

endpackage : mhrm_pkg

// >>> hdl/mhrm_top.sv
// Overview of operation
// RULE1: All host registers sixteen bits, three-bit word address.
// RULE2: Write to address zero loads command word.
// RULE3: Addresses one-three write the selected axis mode bank.
// RULE4: Host selects axis by command write first.
// RULE5: Pattern writes ignored until pattern enable command.
// RULE6: Pattern enabled blocks axis mode register writes.
// RULE7: Host sends pattern disable to restore mode access.
// RULE8: Data words share storage with third-axis patterns.
// RULE9: Reset clears mode, output, interpolation registers.
// RULE10: Address six write holds parameter bits 15-0.
// RULE11: Address seven write holds parameter bits 31-16.
// RULE12: Address four writes outputs, or second-plus pattern.
// RULE13: Address five writes interpolation mode register.
// RULE14: Patterns sit at addresses two to seven.
// RULE15: Address zero read returns main status word.
// RULE16: Addresses one-three read selected axis status words.
// RULE17: Addresses four, five read axis input levels.
// RULE18: Addresses six, seven read captured read data.
// RULE19: Host waits for busy high before next command.
// RULE20: Writes reach all assigned axes, reads one.
// RULE21: Command write executes at once with loaded data.
// RULE22: Read and write decode apart, no side effects.
// RULE23: Axis selection latch follows each command write.
`timescale 1ns/100ps

module mhrm_top #(
  parameter int DATA_W = mhrm_pkg::DATA_W,
  parameter int N_AXES = mhrm_pkg::N_AXES
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic                       host_cs_b,
  input  wire logic                       host_wr_b,
  input  wire logic                       host_rd_b,
  input  wire logic [2:0]                 host_addr,
  input  wire logic [DATA_W-1:0]          host_data_in,
  output logic      [DATA_W-1:0]          host_data_out,
  output logic                            host_data_oe_b,
  input  wire logic [DATA_W-1:0]          main_status_in,
  input  wire logic [N_AXES*DATA_W-1:0]   axis_status_one_in,
  input  wire logic [N_AXES*DATA_W-1:0]   axis_status_two_in,
  input  wire logic [N_AXES*DATA_W-1:0]   axis_status_three_in,
  input  wire logic [DATA_W-1:0]          input_pins_first_in,
  input  wire logic [DATA_W-1:0]          input_pins_second_in,
  input  wire logic [2*DATA_W-1:0]        read_data_value,
  input  wire logic                       read_data_load,
  output logic      [DATA_W-1:0]          command_word,
  output logic                            command_strobe,
  output logic                            command_busy_low,
  output logic      [3:0]                 axis_select,
  output logic      [N_AXES*DATA_W-1:0]   axis_mode_one,
  output logic      [N_AXES*DATA_W-1:0]   axis_mode_two,
  output logic      [N_AXES*DATA_W-1:0]   axis_mode_three,
  output logic      [DATA_W-1:0]          general_output,
  output logic      [3:0]                 general_outputs_low,
  output logic      [DATA_W-1:0]          interpolation_mode,
  output logic      [2*DATA_W-1:0]        write_data,
  output logic      [DATA_W-1:0]          pattern_first_plus,
  output logic      [DATA_W-1:0]          pattern_first_minus,
  output logic      [DATA_W-1:0]          pattern_second_plus,
  output logic      [DATA_W-1:0]          pattern_second_minus,
  output logic                            pattern_enabled
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Picks one axis word out of a bank of four.
  function automatic logic [DATA_W-1:0] axis_slice(
    input logic [N_AXES*DATA_W-1:0] bank,
    input logic [1:0]               idx
  );
    axis_slice = bank[idx*DATA_W +: DATA_W];
  endfunction : axis_slice

  // Reads serve one axis only: the lowest assigned one wins.
  function automatic logic [1:0] first_axis(input logic [3:0] sel);
    first_axis = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (sel[i]) begin
        first_axis = 2'(i);
      end
    end
  endfunction : first_axis

  // ************************************************************
  // Pin synchronisers
  // ************************************************************

  localparam int DAT_W = 3 + 3 * DATA_W;

  logic [2:0]       strb1_r, strb1_nxt, strb2_r, strb2_nxt;
  logic [DAT_W-1:0] dat1_r, dat1_nxt, dat2_r, dat2_nxt;
  logic             wr_prev_r, wr_prev_nxt;
  logic             wr_act, rd_act, wr_evt;
  logic [2:0]       bus_addr;
  logic [DATA_W-1:0] bus_wdata, pins_first, pins_second;

  // The host bus is asynchronous to core_clk, so every pin passes two
  // flops; the first stage feeds only the second.
  always_comb begin
    strb1_nxt   = {host_cs_b, host_wr_b, host_rd_b};
    strb2_nxt   = strb1_r;
    dat1_nxt    = {host_addr, host_data_in, input_pins_first_in,
                   input_pins_second_in};
    dat2_nxt    = dat1_r;
    wr_prev_nxt = wr_act;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strb1_r   <= mhrm_pkg::STROBE_IDLE;
      strb2_r   <= mhrm_pkg::STROBE_IDLE;
      dat1_r    <= '0;
      dat2_r    <= '0;
      wr_prev_r <= 1'b0;
    end else begin
      strb1_r   <= strb1_nxt;
      strb2_r   <= strb2_nxt;
      dat1_r    <= dat1_nxt;
      dat2_r    <= dat2_nxt;
      wr_prev_r <= wr_prev_nxt;
    end
  end

  // Read and write are decoded separately on the same address.
  assign wr_act      = !strb2_r[2] && !strb2_r[1];  // RULE22
  assign rd_act      = !strb2_r[2] && !strb2_r[0];  // RULE22
  assign wr_evt      = wr_act && !wr_prev_r;
  assign bus_addr    = dat2_r[DAT_W-1 -: 3];  // RULE1
  assign bus_wdata   = dat2_r[3*DATA_W-1 -: DATA_W];  // RULE1
  assign pins_first  = dat2_r[2*DATA_W-1 -: DATA_W];
  assign pins_second = dat2_r[DATA_W-1:0];

  // ************************************************************
  // Shared write registers and command path
  // ************************************************************

  logic [DATA_W-1:0]   cmd_r, cmd_nxt;
  logic                strobe_r, strobe_nxt;
  logic                busy_low_r, busy_low_nxt;
  logic [mhrm_pkg::BUSY_W-1:0] busy_cnt_r, busy_cnt_nxt;
  logic [3:0]          sel_r, sel_nxt;
  logic                pat_en_r, pat_en_nxt;
  logic [DATA_W-1:0]   gen_out_r, gen_out_nxt;
  logic [DATA_W-1:0]   interp_r, interp_nxt;
  logic [2*DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0]   pfp_r, pfp_nxt, pfm_r, pfm_nxt;
  logic [DATA_W-1:0]   psp_r, psp_nxt, psm_r, psm_nxt;
  logic [6:0]          cmd_code;

  assign cmd_code = bus_wdata[mhrm_pkg::CMD_CODE_MSB:mhrm_pkg::CMD_CODE_LSB];

  // A command write made while busy is refused outright; taking it
  // would corrupt the command still being accepted by the core.
  always_comb begin
    cmd_nxt      = cmd_r;
    strobe_nxt   = 1'b0;
    sel_nxt      = sel_r;
    pat_en_nxt   = pat_en_r;
    gen_out_nxt  = gen_out_r;
    interp_nxt   = interp_r;
    wdata_nxt    = wdata_r;
    pfp_nxt      = pfp_r;
    pfm_nxt      = pfm_r;
    psp_nxt      = psp_r;
    psm_nxt      = psm_r;
    busy_cnt_nxt = (busy_cnt_r != mhrm_pkg::BUSY_IDLE) ?
                   busy_cnt_r - 4'h1 : busy_cnt_r;
    if (wr_evt) begin
      case (bus_addr)
        mhrm_pkg::ADDR_COMMAND: begin
          if (busy_cnt_r == mhrm_pkg::BUSY_IDLE) begin
            cmd_nxt      = bus_wdata;  // RULE2
            strobe_nxt   = 1'b1;  // RULE21
            busy_cnt_nxt = mhrm_pkg::CMD_ACCEPT_CYCLES;
            sel_nxt      = bus_wdata[mhrm_pkg::CMD_AXIS_MSB:
                                     mhrm_pkg::CMD_AXIS_LSB];  // RULE23
            if (cmd_code == mhrm_pkg::CMD_PATTERN_ENABLE) begin
              pat_en_nxt = 1'b1;  // RULE5
            end else if (cmd_code == mhrm_pkg::CMD_PATTERN_DISABLE) begin
              pat_en_nxt = 1'b0;
            end
          end
        end
        mhrm_pkg::ADDR_MODE_TWO: begin
          pfp_nxt = pat_en_r ? bus_wdata : pfp_r;  // RULE14
        end
        mhrm_pkg::ADDR_MODE_THREE: begin
          pfm_nxt = pat_en_r ? bus_wdata : pfm_r;  // RULE14
        end
        mhrm_pkg::ADDR_OUTPUT: begin
          psp_nxt     = pat_en_r ? bus_wdata : psp_r;  // RULE12
          gen_out_nxt = pat_en_r ? gen_out_r : bus_wdata;  // RULE12
        end
        mhrm_pkg::ADDR_INTERP: begin
          psm_nxt    = pat_en_r ? bus_wdata : psm_r;  // RULE14
          interp_nxt = pat_en_r ? interp_r : bus_wdata;  // RULE13
        end
        mhrm_pkg::ADDR_DATA_LOW: begin
          wdata_nxt[DATA_W-1:0] = bus_wdata;  // RULE10 RULE8
        end
        mhrm_pkg::ADDR_DATA_HIGH: begin
          wdata_nxt[2*DATA_W-1:DATA_W] = bus_wdata;  // RULE11 RULE8
        end
        default: ;
      endcase
    end
    busy_low_nxt = (busy_cnt_nxt == mhrm_pkg::BUSY_IDLE);
  end

  // Everything is reset, to zero except sel_r and busy_low_r, including registers whose contents are
  // left undefined, so simulation never sees unknown values.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r      <= mhrm_pkg::RESET_WORD;
      strobe_r   <= 1'b0;
      busy_low_r <= 1'b1;
      busy_cnt_r <= mhrm_pkg::BUSY_IDLE;
      sel_r      <= mhrm_pkg::RESET_AXIS_SEL;
      pat_en_r   <= 1'b0;  // RULE5
      gen_out_r  <= mhrm_pkg::RESET_WORD;  // RULE9
      interp_r   <= mhrm_pkg::RESET_WORD;  // RULE9
      wdata_r    <= mhrm_pkg::RESET_PARAM;
      pfp_r      <= mhrm_pkg::RESET_WORD;
      pfm_r      <= mhrm_pkg::RESET_WORD;
      psp_r      <= mhrm_pkg::RESET_WORD;
      psm_r      <= mhrm_pkg::RESET_WORD;
    end else begin
      cmd_r      <= cmd_nxt;
      strobe_r   <= strobe_nxt;
      busy_low_r <= busy_low_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      sel_r      <= sel_nxt;
      pat_en_r   <= pat_en_nxt;
      gen_out_r  <= gen_out_nxt;
      interp_r   <= interp_nxt;
      wdata_r    <= wdata_nxt;
      pfp_r      <= pfp_nxt;
      pfm_r      <= pfm_nxt;
      psp_r      <= psp_nxt;
      psm_r      <= psm_nxt;
    end
  end

  // ************************************************************
  // Axis-banked mode registers
  // ************************************************************

  logic [DATA_W-1:0] m1_r [N_AXES];
  logic [DATA_W-1:0] m2_r [N_AXES];
  logic [DATA_W-1:0] m3_r [N_AXES];

  // Several axes may be assigned at once and all take the same word.
  for (genvar g = 0; g < N_AXES; g++) begin : g_axis
    logic [DATA_W-1:0] m1_nxt, m2_nxt, m3_nxt;
    logic              take;

    always_comb begin
      take   = wr_evt && !pat_en_r && sel_r[g];  // RULE3 RULE6 RULE20
      m1_nxt = (take && bus_addr == mhrm_pkg::ADDR_MODE_ONE) ?
               bus_wdata : m1_r[g];
      m2_nxt = (take && bus_addr == mhrm_pkg::ADDR_MODE_TWO) ?
               bus_wdata : m2_r[g];
      m3_nxt = (take && bus_addr == mhrm_pkg::ADDR_MODE_THREE) ?
               bus_wdata : m3_r[g];
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        m1_r[g] <= mhrm_pkg::RESET_WORD;  // RULE9
        m2_r[g] <= mhrm_pkg::RESET_WORD;  // RULE9
        m3_r[g] <= mhrm_pkg::RESET_WORD;  // RULE9
      end else begin
        m1_r[g] <= m1_nxt;
        m2_r[g] <= m2_nxt;
        m3_r[g] <= m3_nxt;
      end
    end

    assign axis_mode_one[g*DATA_W +: DATA_W]   = m1_r[g];
    assign axis_mode_two[g*DATA_W +: DATA_W]   = m2_r[g];
    assign axis_mode_three[g*DATA_W +: DATA_W] = m3_r[g];
  end

  // ************************************************************
  // Read path
  // ************************************************************

  logic [DATA_W-1:0]   dout_r, dout_nxt;
  logic                oe_b_r, oe_b_nxt;
  logic [2*DATA_W-1:0] rdata_r, rdata_nxt;
  logic [1:0]          rd_axis;

  assign rd_axis = first_axis(sel_r);  // RULE20

  // The bus word follows its source while the strobe is held, so a
  // slow host sees live status rather than a stale snapshot.
  always_comb begin
    rdata_nxt = read_data_load ? read_data_value : rdata_r;  // RULE18
    dout_nxt  = dout_r;
    oe_b_nxt  = !rd_act;
    if (rd_act) begin
      case (bus_addr)
        mhrm_pkg::ADDR_COMMAND: dout_nxt = main_status_in;  // RULE15
        mhrm_pkg::ADDR_MODE_ONE: begin
          dout_nxt = axis_slice(axis_status_one_in, rd_axis);  // RULE16
        end
        mhrm_pkg::ADDR_MODE_TWO: begin
          dout_nxt = axis_slice(axis_status_two_in, rd_axis);  // RULE16
        end
        mhrm_pkg::ADDR_MODE_THREE: begin
          dout_nxt = axis_slice(axis_status_three_in, rd_axis);  // RULE16
        end
        mhrm_pkg::ADDR_OUTPUT: dout_nxt = pins_first;  // RULE17
        mhrm_pkg::ADDR_INTERP: dout_nxt = pins_second;  // RULE17
        mhrm_pkg::ADDR_DATA_LOW: dout_nxt = rdata_r[DATA_W-1:0];  // RULE18
        mhrm_pkg::ADDR_DATA_HIGH: begin
          dout_nxt = rdata_r[2*DATA_W-1:DATA_W];  // RULE18
        end
        default: dout_nxt = mhrm_pkg::RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_r  <= mhrm_pkg::RESET_WORD;
      oe_b_r  <= 1'b1;
      rdata_r <= mhrm_pkg::RESET_PARAM;
    end else begin
      dout_r  <= dout_nxt;
      oe_b_r  <= oe_b_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  assign host_data_out        = dout_r;
  assign host_data_oe_b       = oe_b_r;
  assign command_word         = cmd_r;
  assign command_strobe       = strobe_r;
  assign command_busy_low     = busy_low_r;
  assign axis_select          = sel_r;
  assign general_output       = gen_out_r;
  assign general_outputs_low  = gen_out_r[mhrm_pkg::OUT_LOW_MSB:0];
  assign interpolation_mode   = interp_r;
  assign write_data           = wdata_r;
  assign pattern_first_plus   = pfp_r;
  assign pattern_first_minus  = pfm_r;
  assign pattern_second_plus  = psp_r;
  assign pattern_second_minus = psm_r;
  assign pattern_enabled      = pat_en_r;

  // ************************************************************
  // Assertions
  // ************************************************************

  a_command_take: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wr_evt && bus_addr == 3'h0 && busy_low_r) |=>
      (strobe_r && cmd_r == $past(bus_wdata) && !busy_low_r))  // RULE2
    else $error("command write not taken");
  a_busy_window: assert property (@(posedge core_clk) disable iff (!rst_b)
    strobe_r |-> (!busy_low_r)[*6] ##1 busy_low_r)  // RULE21
    else $error("busy window length wrong");
  a_mode_bank: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wr_evt && bus_addr == 3'h2 && !pat_en_r && sel_r[0] && sel_r[2]) |=>
      (m2_r[0] == $past(bus_wdata) && m2_r[2] == $past(bus_wdata)))  // RULE3
    else $error("mode write missed an assigned axis");
  a_pattern_lock: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wr_evt && bus_addr == 3'h2 && !pat_en_r) |=> $stable(pfp_r))  // RULE5
    else $error("pattern written while disabled");
  a_mode_lock: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wr_evt && pat_en_r && bus_addr == 3'h2) |=>
      ($stable(m2_r[0]) && pfp_r == $past(bus_wdata)))  // RULE6
    else $error("mode written while patterns enabled");
  a_shared_data: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wr_evt && bus_addr == 3'h7) |=>
    (wdata_r[31:16] == $past(bus_wdata) && $stable(wdata_r[15:0])))  // RULE11
    else $error("high data word not stored");
  a_output_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wr_evt && bus_addr == 3'h4 && !pat_en_r) |=>
      (general_outputs_low == $past(bus_wdata[3:0]) && $stable(psp_r)))  // RULE12
    else $error("output register write wrong");
  a_status_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rd_act && bus_addr == 3'h0) |=>
      (!host_data_oe_b && host_data_out == $past(main_status_in)))  // RULE15
    else $error("main status read wrong");
  a_read_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rd_act && !wr_act) |=>
      ($stable(gen_out_r) && $stable(interp_r) && !strobe_r))  // RULE22
    else $error("read had a side effect");

endmodule : mhrm_top

// >>> tb/mhrm_host_model.sv
`timescale 1ns/100ps
// ************************************************************
// Host processor model on the parallel register port
// ************************************************************
module mhrm_host_model (
  input  wire logic        core_clk,
  input  wire logic        command_busy_low,
  input  wire logic [15:0] host_data_out,
  input  wire logic        host_data_oe_b,
  output logic             host_cs_b,
  output logic             host_wr_b,
  output logic             host_rd_b,
  output logic [2:0]       host_addr,
  output logic [15:0]      host_data_in
);
  // Idle bus, strobes high.
  initial begin
    host_cs_b    = 1'b1;
    host_wr_b    = 1'b1;
    host_rd_b    = 1'b1;
    host_addr    = 3'h0;
    host_data_in = 16'h0000;
  end

  // Address and data settle two cycles before the strobe, because the
  // device samples them through the same synchroniser as the strobe.
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #2;
    host_addr    = a;
    host_data_in = d;
    repeat (2) @(posedge core_clk);
    #2;
    host_cs_b = 1'b0;
    host_wr_b = 1'b0;
    repeat (5) @(posedge core_clk);
    #2;
    host_cs_b    = 1'b1;
    host_wr_b    = 1'b1;
    host_data_in = ~d; // A released bus must not show the old word.
    repeat (3) @(posedge core_clk);
  endtask : wr

  // Commands wait for the busy flag, so none is dropped.
  task automatic cmd(input logic [15:0] d);
    // A busy flag that never returns is left to the bench watchdog.
    while (command_busy_low !== 1'b1) begin
      @(posedge core_clk);
    end
    wr(3'h0, d);
  endtask : cmd

  // Axis selection by a no-operation command with the axes assigned.
  task automatic sel(input logic [3:0] axes);
    cmd({4'h0, axes, 8'h0F});
  endtask : sel

  // One read cycle; the word is taken while the strobe is still held.
  task automatic rd(input logic [2:0] a, output logic [15:0] q,
                    output logic oe_b);
    @(posedge core_clk);
    #2;
    host_addr = a;
    repeat (2) @(posedge core_clk);
    #2;
    host_cs_b = 1'b0;
    host_rd_b = 1'b0;
    repeat (5) @(posedge core_clk);
    #2;
    q         = host_data_out;
    oe_b      = host_data_oe_b;
    host_cs_b = 1'b1;
    host_rd_b = 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : rd
endmodule : mhrm_host_model

// >>> tb/mhrm_top_tb.sv
`timescale 1ns/100ps
// ************************************************************
// Self-checking bench for the host register map
// ************************************************************
module mhrm_top_tb;
  logic        core_clk, rst_b, read_data_load;
  logic        cs_b, wr_b, rd_b, oe_b, strobe, busy_low, pat_en;
  logic        bus_oe_b;
  logic [2:0]  addr;
  logic [3:0]  axis_sel, gen_low;
  logic [15:0] din, dout, cmd_w, gen_out, interp, q;
  logic [15:0] main_st, pins_a, pins_b, pfp, pfm, psp, psm;
  logic [31:0] rd_value, wdata;
  logic [63:0] st1, st2, st3, mode1, mode2, mode3;
  int          error_cnt, n_checks;
  int          n_strobes = 0;

  mhrm_top dut (.core_clk(core_clk), .rst_b(rst_b), .host_cs_b(cs_b),
    .host_wr_b(wr_b), .host_rd_b(rd_b), .host_addr(addr),
    .host_data_in(din), .host_data_out(dout), .host_data_oe_b(bus_oe_b),
    .main_status_in(main_st), .axis_status_one_in(st1),
    .axis_status_two_in(st2), .axis_status_three_in(st3),
    .input_pins_first_in(pins_a), .input_pins_second_in(pins_b),
    .read_data_value(rd_value), .read_data_load(read_data_load),
    .command_word(cmd_w), .command_strobe(strobe),
    .command_busy_low(busy_low), .axis_select(axis_sel),
    .axis_mode_one(mode1), .axis_mode_two(mode2), .axis_mode_three(mode3),
    .general_output(gen_out), .general_outputs_low(gen_low),
    .interpolation_mode(interp), .write_data(wdata),
    .pattern_first_plus(pfp), .pattern_first_minus(pfm),
    .pattern_second_plus(psp), .pattern_second_minus(psm),
    .pattern_enabled(pat_en));

  mhrm_host_model host (.core_clk(core_clk), .command_busy_low(busy_low),
    .host_data_out(dout), .host_data_oe_b(bus_oe_b), .host_cs_b(cs_b),
    .host_wr_b(wr_b), .host_rd_b(rd_b), .host_addr(addr),
    .host_data_in(din));

  // ************************************************************
  // Clock, comparison and verdict
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Counts command pulses; a strobe that stands too long counts twice.
  always @(posedge core_clk) begin
    if (strobe === 1'b1) begin
      n_strobes <= n_strobes + 1;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Cleared registers after reset; the unknown ones are not judged.
  task automatic t_reset;
    check(mode1, 64'h0);
    check(mode2, 64'h0);
    check(mode3, 64'h0);
    check(gen_out, 16'h0000);
    check(interp, 16'h0000);
    check(pat_en, 1'b0);
  endtask : t_reset

  // Banked mode writes land only in the selected axes.
  task automatic t_bank;
    host.sel(4'h2);
    check(axis_sel, 4'h2);
    host.wr(3'h1, 16'hA5C3);
    check(mode1, 64'h0000_0000_A5C3_0000);
    host.sel(4'h5);
    host.wr(3'h2, 16'h3C5A);
    check(mode2, 64'h0000_3C5A_0000_3C5A);
    host.wr(3'h3, 16'h0F0F);
    check(mode3, 64'h0000_0F0F_0000_0F0F);
    host.rd(3'h1, q, oe_b);
    check(q, st1[15:0]);
    host.rd(3'h2, q, oe_b);
    check(q, st2[15:0]);
    host.rd(3'h3, q, oe_b);
    check(q, st3[15:0]);
  endtask : t_bank

  // Output, interpolation mode and parameter words, then a command.
  task automatic t_plain;
    host.wr(3'h4, 16'h9ABC);
    check(gen_out, 16'h9ABC);
    check(gen_low, 4'hC);
    host.wr(3'h5, 16'h4321);
    check(interp, 16'h4321);
    host.wr(3'h7, 16'h2468);
    host.wr(3'h6, 16'h1357);
    check(wdata, 32'h2468_1357);
    host.cmd(16'h0183);
    check(cmd_w, 16'h0183);
    check(axis_sel, 4'h1);
    check(busy_low, 1'b0);
    @(posedge core_clk);
    #2;
    check(busy_low, 1'b1);
  endtask : t_plain

  // Pattern writes refused before enable, mode writes refused after.
  task automatic t_pattern;
    int i;
    host.wr(3'h4, 16'h5555);
    check(psp, 16'h0000);
    host.cmd(16'h0236);
    check(pat_en, 1'b1);
    for (i = 2; i < 8; i++) begin
      host.wr(3'(i), 16'h1000 + 16'(i) * 16'h0111);
    end
    host.wr(3'h1, 16'hFFFF);
    check(pfp, 16'h1222);
    check(pfm, 16'h1333);
    check(psp, 16'h1444);
    check(psm, 16'h1555);
    check(wdata, 32'h1777_1666);
    check(mode1, 64'h0000_0000_A5C3_0000);
    check(mode2, 64'h0000_3C5A_0000_3C5A);
    check(gen_out, 16'h5555);
    host.cmd(16'h0837);
    check(pat_en, 1'b0);
    host.wr(3'h1, 16'h7E7E);
    check(mode1, 64'h7E7E_0000_A5C3_0000);
  endtask : t_pattern

  // Read-only words come back without touching the written registers.
  task automatic t_read;
    host.rd(3'h0, q, oe_b);
    check(q, main_st);
    check(oe_b, 1'b0);
    host.rd(3'h4, q, oe_b);
    check(q, pins_a);
    host.rd(3'h5, q, oe_b);
    check(q, pins_b);
    @(posedge core_clk);
    #2;
    read_data_load = 1'b1;
    @(posedge core_clk);
    #2;
    read_data_load = 1'b0;
    host.rd(3'h6, q, oe_b);
    check(q, 16'hBEEF);
    host.rd(3'h7, q, oe_b);
    check(q, 16'hCAFE);
    check(cmd_w, 16'h0837);
    check(wdata, 32'h1777_1666);
    check(n_strobes, 5);
  endtask : t_read

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    error_cnt      = 0;
    n_checks       = 0;
    rst_b          = 1'b0;
    read_data_load = 1'b0;
    main_st        = 16'h5A01;
    pins_a         = 16'h3C02;
    pins_b         = 16'hC303;
    rd_value       = 32'hCAFE_BEEF;
    st1            = 64'h1A11_1B11_1C11_1D11;
    st2            = 64'h2A22_2B22_2C22_2D22;
    st3            = 64'h3A33_3B33_3C33_3D33;
    repeat (5) @(posedge core_clk);
    #2;
    rst_b = 1'b1;
    t_reset;
    t_bank;
    t_plain;
    t_pattern;
    t_read;
    // A second reset in mid-run must clear again.
    #2;
    rst_b = 1'b0;
    repeat (2) @(posedge core_clk);
    #2;
    rst_b = 1'b1;
    t_reset;
    tally_and_finish;
  end

  // The sequence needs some three hundred and forty cycles; nearly sixty times that is a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule : mhrm_top_tb
